/* File: rtl/monitor_status_limit_flags.sv */
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
module monitor_status_limit_flags
	import monitor_flags_pkg::*;
#(
	parameter int TICK_CYCLES = TIMER_TICK_CYCLES,
	parameter int FANS = 4,
	parameter int TEMPS = 3
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_irq,
	input wire logic [7:0] i_rail_2v5_reading,
	input wire logic [7:0] i_supply_reading,
	input wire logic [TEMPS-1:0][7:0] i_temp_reading,
	input wire logic [TEMPS-1:0][7:0] i_temp_low_limit,
	input wire logic [TEMPS-1:0][7:0] i_temp_high_limit,
	input wire logic [FANS-1:0][15:0] i_tach_reading,
	input wire logic [FANS-1:0][15:0] i_tach_min_limit,
	input wire logic [2:0] i_pwm_active,
	input wire logic i_overheat_over,
	input wire logic i_overheat_released,
	input wire logic i_timer_pin_mode,
	input wire logic i_overheat_signal,
	input wire logic i_diode_one_fault,
	input wire logic i_diode_two_fault
);

	// ========================================
	// Bus decode
	logic [7:0] idx;
	logic mapped_rd;
	logic req;
	logic commit;
	logic wr_commit;
	logic rd_commit;
	logic wr_lane;
	logic waitrequest_q;
	logic [31:0] readdata_q;
	logic [7:0] rd_snap_a_q;
	logic [7:0] rd_snap_b_q;

	assign idx = i_avs_address[IDX_LSB +: 8];
	assign req = i_avs_read | i_avs_write;
	// A request completes at the edge where waitrequest is seen low
	assign commit = req & ~waitrequest_q;
	assign wr_commit = commit & i_avs_write;
	assign rd_commit = commit & i_avs_read;
	assign wr_lane = wr_commit & i_avs_byteenable[0];

	// ========================================
	// Limit registers
	logic [7:0] rail_2v5_low_limit_q;
	logic [7:0] rail_2v5_high_limit_q;
	logic [7:0] supply_low_limit_q;
	logic [7:0] supply_high_limit_q;
	logic [7:0] timer_limit_q;

	// No write-protect term here: the lock never reaches these
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rail_2v5_low_limit_q <= LOW_LIMIT_RESET;
			rail_2v5_high_limit_q <= HIGH_LIMIT_RESET;
			supply_low_limit_q <= LOW_LIMIT_RESET;
			supply_high_limit_q <= HIGH_LIMIT_RESET;
			timer_limit_q <= TIMER_LIMIT_RESET;
		end else if (wr_lane) begin
			unique case (idx)
				IDX_RAIL_2V5_LOW: rail_2v5_low_limit_q <= i_avs_writedata[7:0];
				IDX_RAIL_2V5_HIGH: rail_2v5_high_limit_q <= i_avs_writedata[7:0];
				IDX_SUPPLY_LOW: supply_low_limit_q <= i_avs_writedata[7:0];
				IDX_SUPPLY_HIGH: supply_high_limit_q <= i_avs_writedata[7:0];
				IDX_TIMER_LIMIT: timer_limit_q <= i_avs_writedata[7:0];
				default: ;
			endcase
		end
	end

	// ========================================
	// Violation conditions
	logic rail_2v5_bad;
	logic supply_bad;
	logic [TEMPS-1:0] temp_bad;
	logic [FANS-1:0] fan_bad;
	logic [FANS-1:0] fan_pwm_on;
	logic overheat_cond_q;
	logic timer_cond;

	// Strictly above high, at or below low
	assign rail_2v5_bad = (i_rail_2v5_reading > rail_2v5_high_limit_q)
		| (i_rail_2v5_reading <= rail_2v5_low_limit_q);
	assign supply_bad = (i_supply_reading > supply_high_limit_q)
		| (i_supply_reading <= supply_low_limit_q);

	// Fan four tracks the third output
	assign fan_pwm_on = {i_pwm_active[2], i_pwm_active};

	genvar g;
	generate
		for (g = 0; g < TEMPS; g++) begin : g_temp
			// Two's complement readings; one degree past sets the flag
			assign temp_bad[g] =
				($signed(i_temp_reading[g]) > $signed(i_temp_high_limit[g]))
				| ($signed(i_temp_reading[g]) <= $signed(i_temp_low_limit[g]));
		end
		for (g = 0; g < FANS; g++) begin : g_fan
			// Longer tach count means slower fan
			assign fan_bad[g] = fan_pwm_on[g]
				& (i_tach_reading[g] > i_tach_min_limit[g])
				& (i_tach_min_limit[g] != TACH_ALL_ONES)
				& (i_tach_min_limit[g] != TACH_ALL_ZEROS);
		end
	endgenerate

	// Condition persists until the temperature drops past the hysteresis
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			overheat_cond_q <= 1'b0;
		end else if (i_overheat_over) begin
			overheat_cond_q <= 1'b1;
		end else if (i_overheat_released) begin
			overheat_cond_q <= 1'b0;
		end
	end

	// ========================================
	// Overheat assertion timer
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	logic [TICK_W-1:0] tick_cnt_q;
	logic tick;
	logic [7:0] accum_q;

	assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

	always_ff @(posedge i_ref_clk) begin
		if (i_rst || !i_overheat_signal || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + TICK_W'(1);
		end
	end

	// Saturates rather than wraps so a long assertion is never missed
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || !i_timer_pin_mode) begin
			accum_q <= '0;
		end else if (rd_commit && idx == IDX_FLAGS_B && !timer_cond) begin
			accum_q <= '0;
		end else if (tick && i_overheat_signal && accum_q != 8'hFF) begin
			accum_q <= accum_q + 8'h01;
		end
	end

	assign timer_cond = accum_q > timer_limit_q;

	// ========================================
	// Sticky flags
	logic [7:0] cond_a;
	logic [7:0] cond_b;
	logic [7:0] flags_a_q;
	logic [7:0] flags_b_q;
	logic [7:0] clr_a;
	logic [7:0] clr_b;
	logic [7:0] flags_a_d;
	logic [7:0] flags_b_d;
	logic [7:0] view_a;

	always_comb begin
		cond_a = '0;
		cond_a[A_RAIL_2V5] = rail_2v5_bad;
		cond_a[A_SUPPLY] = supply_bad;
		cond_a[A_REMOTE_TWO:A_REMOTE_ONE] = temp_bad;
		cond_b = '0;
		cond_b[B_OVERHEAT] = overheat_cond_q;
		cond_b[B_FAN_FOURTH:B_FAN_FIRST] = fan_bad;
		if (i_timer_pin_mode) begin
			cond_b[B_FAN_FOURTH] = timer_cond;
		end
		cond_b[B_DIODE_ONE] = i_diode_one_fault;
		cond_b[B_DIODE_TWO] = i_diode_two_fault;
	end

	// Only bits actually returned by the read are eligible for clearing
	assign clr_a = (rd_commit && idx == IDX_FLAGS_A) ? rd_snap_a_q : '0;
	assign clr_b = (rd_commit && idx == IDX_FLAGS_B) ? rd_snap_b_q : '0;
	// Live condition re-sets in the clearing cycle, so set wins
	assign flags_a_d = (cond_a | (flags_a_q & ~clr_a)) & A_IMPL_MASK;
	assign flags_b_d = (cond_b | (flags_b_q & ~clr_b)) & B_IMPL_MASK;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			flags_a_q <= FLAGS_RESET;
			flags_b_q <= FLAGS_RESET;
		end else begin
			flags_a_q <= flags_a_d;
			flags_b_q <= flags_b_d;
		end
	end

	always_comb begin
		view_a = flags_a_q;
		view_a[A_SUMMARY] = |flags_b_q;
	end

	// ========================================
	// Interrupt status, enable and clear
	logic [1:0] irq_status_q;
	logic [1:0] irq_enable_q;
	logic [1:0] irq_event;
	logic [1:0] irq_clr;
	logic [1:0] irq_status_d;
	logic irq_q;

	assign irq_event[IRQ_EV_A] = |(flags_a_d & ~flags_a_q);
	assign irq_event[IRQ_EV_B] = |(flags_b_d & ~flags_b_q);
	assign irq_clr = (wr_lane && idx == IDX_IRQ_CLEAR) ?
		i_avs_writedata[1:0] : '0;
	assign irq_status_d = irq_event | (irq_status_q & ~irq_clr);

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			irq_status_q <= IRQ_RESET;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			irq_enable_q <= IRQ_RESET;
		end else if (wr_lane && idx == IDX_IRQ_ENABLE) begin
			irq_enable_q <= i_avs_writedata[1:0];
		end
	end

	// Built from next values so the pin tracks status without lag
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			irq_q <= 1'b0;
		end else if (wr_lane && idx == IDX_IRQ_ENABLE) begin
			irq_q <= |(irq_status_d & i_avs_writedata[1:0]);
		end else begin
			irq_q <= |(irq_status_d & irq_enable_q);
		end
	end

	// ========================================
	// Bus answer: one wait cycle, read data stands while waitrequest low
	logic [7:0] rd_byte;

	always_comb begin
		mapped_rd = 1'b1;
		unique case (idx)
			IDX_FLAGS_A: rd_byte = view_a;
			IDX_FLAGS_B: rd_byte = flags_b_q;
			IDX_RAIL_2V5_LOW: rd_byte = rail_2v5_low_limit_q;
			IDX_RAIL_2V5_HIGH: rd_byte = rail_2v5_high_limit_q;
			IDX_SUPPLY_LOW: rd_byte = supply_low_limit_q;
			IDX_SUPPLY_HIGH: rd_byte = supply_high_limit_q;
			IDX_TIMER_LIMIT: rd_byte = timer_limit_q;
			IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status_q};
			IDX_IRQ_ENABLE: rd_byte = {6'h00, irq_enable_q};
			default: begin
				rd_byte = 8'h00;
				mapped_rd = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			waitrequest_q <= 1'b1;
			readdata_q <= 32'h0000_0000;
			rd_snap_a_q <= 8'h00;
			rd_snap_b_q <= 8'h00;
		end else if (req && waitrequest_q) begin
			waitrequest_q <= 1'b0;
			readdata_q <= (i_avs_read && mapped_rd) ?
				{24'h00_0000, rd_byte} : 32'h0000_0000;
			rd_snap_a_q <= flags_a_q;
			rd_snap_b_q <= flags_b_q;
		end else begin
			waitrequest_q <= 1'b1;
		end
	end

	assign o_avs_readdata = readdata_q;
	assign o_avs_waitrequest = waitrequest_q;
	assign o_irq = irq_q;

endmodule // monitor_status_limit_flags

/* File: rtl/monitor_flags_pkg.sv */
// Operation
// - Bit0 2.5V fault, bit2 supply fault
// - Bits4-6 remote one, local, remote two temps
// - Read clears flag only when condition gone
// - Register one bit7 ORs register two
// - Overheat flag clears after hysteresis release only
// - Register two bits2-5 flag fans one-four
// - No fan flag while its output off
// - Timer mode: bit5 from accumulated overheat time
// - Bits6-7 flag diode one and two faults
// - High violation only when strictly above limit
// - Low violation when at or below limit
// - Write-protect latch never blocks voltage limits
// - Both flag registers reset to zero
// - Temperature one degree past limit sets flag
// - Fan limit all ones or zeros: no flag
package monitor_flags_pkg;

	// ========================================
	// Register indices (byte address = 4 * index)
	localparam logic [7:0] IDX_FLAGS_A = 8'h41;
	localparam logic [7:0] IDX_FLAGS_B = 8'h42;
	localparam logic [7:0] IDX_RAIL_2V5_LOW = 8'h44;
	localparam logic [7:0] IDX_RAIL_2V5_HIGH = 8'h45;
	localparam logic [7:0] IDX_SUPPLY_LOW = 8'h48;
	localparam logic [7:0] IDX_SUPPLY_HIGH = 8'h49;
	localparam logic [7:0] IDX_TIMER_LIMIT = 8'h7A;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h80;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h81;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h82;
	localparam int ADDR_W = 10;
	localparam int IDX_LSB = 2;

	// ========================================
	// Reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] LOW_LIMIT_RESET = 8'h00;
	localparam logic [7:0] HIGH_LIMIT_RESET = 8'hFF;
	localparam logic [7:0] TIMER_LIMIT_RESET = 8'hFF;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// ========================================
	// Field positions
	localparam int A_RAIL_2V5 = 0;
	localparam int A_SUPPLY = 2;
	localparam int A_REMOTE_ONE = 4;
	localparam int A_LOCAL = 5;
	localparam int A_REMOTE_TWO = 6;
	localparam int A_SUMMARY = 7;
	localparam int B_OVERHEAT = 1;
	localparam int B_FAN_FIRST = 2;
	localparam int B_FAN_FOURTH = 5;
	localparam int B_DIODE_ONE = 6;
	localparam int B_DIODE_TWO = 7;
	localparam int IRQ_EV_A = 0;
	localparam int IRQ_EV_B = 1;
	localparam logic [7:0] A_IMPL_MASK = 8'h75;
	localparam logic [7:0] B_IMPL_MASK = 8'hFE;

	// ========================================
	// Fan limit sentinels and timing
	localparam logic [15:0] TACH_ALL_ONES = 16'hFFFF;
	localparam logic [15:0] TACH_ALL_ZEROS = 16'h0000;
	localparam int CLK_HZ = 25_000_000;
	localparam int TIMER_TICK_US = 1000;
	localparam int TIMER_TICK_CYCLES = CLK_HZ / 1_000_000 * TIMER_TICK_US;

endpackage

/* File: bench/monitor_status_limit_flags_monitor.sv */
`timescale 1ns/100ps
module monitor_status_limit_flags_monitor
	import monitor_flags_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic o_irq,
	input wire logic i_overheat_over,
	input wire logic i_diode_one_fault
);
	// ========================================
	// Bus and flag checks
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	logic done;
	logic [7:0] idx;
	logic [7:0] rb;
	assign done = i_avs_read && !o_avs_waitrequest;
	assign idx = i_avs_address[9:2];
	assign rb = o_avs_readdata[7:0];
	chk_reset_idle: assert property (disable iff (1'b0) i_rst |=>
		o_avs_waitrequest && !o_irq && o_avs_readdata == 32'h0)
		else $error("reset state wrong");
	chk_one_wait: assert property ((i_avs_read || i_avs_write) &&
		o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("request not answered after one wait");
	chk_wait_back: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_reserved_a: assert property (done && idx == IDX_FLAGS_A |->
		o_avs_readdata[31:8] == 24'h0 && !rb[1] && !rb[3])
		else $error("reserved bit set in first flag register");
	chk_reserved_b: assert property (done && idx == IDX_FLAGS_B |->
		o_avs_readdata[31:8] == 24'h0 && !rb[0])
		else $error("reserved bit set in second flag register");
	// Two samples back: the read byte is loaded one edge before completion
	chk_diode_seen: assert property (done && idx == IDX_FLAGS_B &&
		$past(i_diode_one_fault, 2) && $past(i_diode_one_fault, 3) |->
		rb[B_DIODE_ONE]) else $error("diode fault not flagged");
	chk_summary_or: assert property (done && idx == IDX_FLAGS_A &&
		$past(i_diode_one_fault, 2) && $past(i_diode_one_fault, 3) |->
		rb[A_SUMMARY]) else $error("summary bit missing");
	chk_overheat_seen: assert property (done && idx == IDX_FLAGS_B &&
		$past(i_overheat_over, 3) && $past(i_overheat_over, 4) |->
		rb[B_OVERHEAT]) else $error("overheat not flagged");
	chk_unmapped_zero: assert property (done &&
		(idx == 8'h00 || idx == IDX_IRQ_CLEAR) |-> o_avs_readdata == 32'h0)
		else $error("unmapped or clear register read not zero");
	cover property (done && idx == IDX_FLAGS_A && rb[A_SUMMARY]);
	cover property (done && idx == IDX_FLAGS_B && rb[B_OVERHEAT]);
	cover property ($rose(o_irq));
endmodule // monitor_status_limit_flags_monitor

bind monitor_status_limit_flags monitor_status_limit_flags_monitor
	i_monitor_status_limit_flags_monitor (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.o_irq(o_irq), .i_overheat_over(i_overheat_over),
	.i_diode_one_fault(i_diode_one_fault));

/* File: bench/monitor_status_limit_flags_tb.sv */
`timescale 1ns/100ps
module monitor_status_limit_flags_tb;
	import monitor_flags_pkg::*;
	// ========================================
	// Stimulus state
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [9:0] addr = 10'h000;
	logic rd_r = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdat;
	logic wreq;
	logic irq;
	logic [31:0] got;
	logic [7:0] rail = 8'h80;
	logic [7:0] sup = 8'h80;
	logic [2:0][7:0] temp = 24'h0;
	logic [3:0][15:0] tach = {4{16'h0100}};
	logic [3:0][15:0] tmin = {4{16'h1000}};
	logic [2:0] pwm = 3'h7;
	logic ov = 1'b0;
	logic rel = 1'b1;
	logic tmode = 1'b0;
	logic osig = 1'b0;
	logic d1 = 1'b0;
	logic d2 = 1'b0;
	int fail_count = 0;
	int checks_done = 0;
	always #20 clk = ~clk;
	// Short tick keeps the overheat timer test to a few dozen cycles
	monitor_status_limit_flags #(.TICK_CYCLES(4)) i_monitor_status_limit_flags (
		.i_ref_clk(clk), .i_rst(rst), .i_avs_address(addr),
		.i_avs_read(rd_r), .i_avs_write(wr), .i_avs_writedata(wdat),
		.i_avs_byteenable(be), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wreq), .o_irq(irq), .i_rail_2v5_reading(rail),
		.i_supply_reading(sup), .i_temp_reading(temp),
		.i_temp_low_limit({3{8'h81}}), .i_temp_high_limit({3{8'h20}}),
		.i_tach_reading(tach), .i_tach_min_limit(tmin), .i_pwm_active(pwm),
		.i_overheat_over(ov), .i_overheat_released(rel),
		.i_timer_pin_mode(tmode), .i_overheat_signal(osig),
		.i_diode_one_fault(d1), .i_diode_two_fault(d2));
	// ========================================
	// Bus and compare helpers
	task automatic chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// Values read right after an edge are the ones sampled at that edge
	task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge clk);
		addr <= {i, 2'b00};
		rd_r <= ~w;
		wr <= w;
		wdat <= {24'h0, d};
		@(posedge clk);
		while (wreq !== 1'b0) @(posedge clk);
		got = rdat;
		rd_r <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		acc(1'b0, i, 8'h00);
		chk($sformatf("reg %h", i), got, {24'h0, e});
	endtask
	// ========================================
	// Scenarios
	task automatic t_reset;
		rd(IDX_FLAGS_A, 8'h00);
		rd(IDX_FLAGS_B, 8'h00);
		rd(IDX_RAIL_2V5_HIGH, 8'hFF);
		rd(IDX_SUPPLY_HIGH, 8'hFF);
		acc(1'b1, IDX_FLAGS_A, 8'hFF);
		rd(IDX_FLAGS_A, 8'h00);
		be <= 4'h0;
		acc(1'b1, IDX_RAIL_2V5_LOW, 8'h55);
		be <= 4'hF;
		rd(IDX_RAIL_2V5_LOW, 8'h00);
		rd(8'h00, 8'h00);
	endtask
	task automatic put(input int v, input logic [7:0] x);
		if (v != 0) sup <= x;
		else rail <= x;
	endtask
	task automatic t_volt(input int v);
		logic [7:0] b;
		logic [7:0] m;
		b = v ? IDX_SUPPLY_LOW : IDX_RAIL_2V5_LOW;
		m = v ? 8'h04 : 8'h01;
		acc(1'b1, b + 8'h01, 8'h90);
		acc(1'b1, b, 8'h70);
		rd(b + 8'h01, 8'h90);
		put(v, 8'h90);
		rd(IDX_FLAGS_A, 8'h00);
		put(v, 8'h91);
		rd(IDX_FLAGS_A, m);
		rd(IDX_FLAGS_A, m);
		put(v, 8'h70);
		rd(IDX_FLAGS_A, m);
		put(v, 8'h71);
		rd(IDX_FLAGS_A, m);
		rd(IDX_FLAGS_A, 8'h00);
	endtask
	// One-cycle violation lands on the clearing edge of a read
	task automatic t_race;
		sup <= 8'hA0;
		rd(IDX_FLAGS_A, 8'h04);
		sup <= 8'h80;
		fork
			rd(IDX_FLAGS_A, 8'h04);
			begin
				repeat (2) @(posedge clk);
				sup <= 8'hA0;
				@(posedge clk);
				sup <= 8'h80;
			end
		join
		rd(IDX_FLAGS_A, 8'h04);
		rd(IDX_FLAGS_A, 8'h00);
	endtask
	task automatic t_temp(input int k);
		temp[k] <= 8'h21;
		rd(IDX_FLAGS_A, 8'h10 << k);
		temp[k] <= 8'h20;
		rd(IDX_FLAGS_A, 8'h10 << k);
		rd(IDX_FLAGS_A, 8'h00);
		temp[k] <= 8'h81;
		rd(IDX_FLAGS_A, 8'h10 << k);
		temp[k] <= 8'h82;
		rd(IDX_FLAGS_A, 8'h10 << k);
		rd(IDX_FLAGS_A, 8'h00);
	endtask
	task automatic t_b;
		d1 <= 1'b1;
		d2 <= 1'b1;
		rd(IDX_FLAGS_B, 8'hC0);
		d2 <= 1'b0;
		rd(IDX_FLAGS_A, 8'h80);
		rd(IDX_FLAGS_B, 8'hC0);
		rd(IDX_FLAGS_B, 8'h40);
		d1 <= 1'b0;
		rd(IDX_FLAGS_B, 8'h40);
		rd(IDX_FLAGS_A, 8'h00);
		ov <= 1'b1;
		rel <= 1'b0;
		// Overheat latch adds one cycle before the flag
		@(posedge clk);
		rd(IDX_FLAGS_B, 8'h02);
		ov <= 1'b0;
		rd(IDX_FLAGS_B, 8'h02);
		rd(IDX_FLAGS_B, 8'h02);
		rel <= 1'b1;
		rd(IDX_FLAGS_B, 8'h02);
		rd(IDX_FLAGS_B, 8'h00);
	endtask
	task automatic t_fan;
		pwm <= 3'h0;
		tach <= {4{16'h2000}};
		rd(IDX_FLAGS_B, 8'h00);
		pwm <= 3'h7;
		tmin <= {4{16'hFFFF}};
		rd(IDX_FLAGS_B, 8'h00);
		tmin <= {4{16'h0000}};
		rd(IDX_FLAGS_B, 8'h00);
		tmin <= {4{16'h1000}};
		pwm <= 3'h4;
		rd(IDX_FLAGS_B, 8'h30);
		pwm <= 3'h3;
		rd(IDX_FLAGS_B, 8'h3C);
		tach <= {4{16'h0100}};
		rd(IDX_FLAGS_B, 8'h0C);
		rd(IDX_FLAGS_B, 8'h00);
	endtask
	task automatic t_timer;
		acc(1'b1, IDX_TIMER_LIMIT, 8'h02);
		tmode <= 1'b1;
		osig <= 1'b1;
		repeat (20) @(posedge clk);
		osig <= 1'b0;
		rd(IDX_FLAGS_B, 8'h20);
		tmode <= 1'b0;
		rd(IDX_FLAGS_B, 8'h20);
		rd(IDX_FLAGS_B, 8'h00);
	endtask
	task automatic t_irq;
		// Earlier scenarios left events pending
		acc(1'b1, IDX_IRQ_CLEAR, 8'h03);
		rd(IDX_IRQ_STATUS, 8'h00);
		acc(1'b1, IDX_IRQ_ENABLE, 8'h01);
		rail <= 8'h95;
		rd(IDX_IRQ_STATUS, 8'h01);
		chk("irq", irq, 1'b1);
		rail <= 8'h80;
		acc(1'b1, IDX_IRQ_CLEAR, 8'h01);
		rd(IDX_IRQ_CLEAR, 8'h00);
		chk("irq", irq, 1'b0);
		acc(1'b1, IDX_IRQ_ENABLE, 8'h00);
		rd(IDX_FLAGS_A, 8'h01);
		rail <= 8'h95;
		rd(IDX_IRQ_STATUS, 8'h01);
		chk("irq", irq, 1'b0);
	endtask
	// ========================================
	// Run control
	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_volt(0);
		t_volt(1);
		t_race();
		for (int k = 0; k < 3; k++) t_temp(k);
		t_b();
		t_fan();
		t_timer();
		t_irq();
		report_and_stop();
	end
endmodule // monitor_status_limit_flags_tb
